//--- pkg/cusic_consts.vh
// Constants of the card reader/punch station controller.
// Assumes a 100 MHz clock and the APB slave map chosen for this block.
`ifndef CUSIC_CONSTS_VH
`define CUSIC_CONSTS_VH

// ****************************************
// Timing
// ****************************************
`define CUSIC_CLK_PERIOD_NS 10
`define CUSIC_COL_TIME_NS 1000000
// Column time over clock period, sized to the 20-bit column timer
`define CUSIC_COL_CYCLES 20'd100000
`define CUSIC_COLS_PER_CARD 7'd80

// ****************************************
// Stations
// ****************************************
`define CUSIC_STN_ZERO 2'h0
`define CUSIC_STN_READER 2'h1
`define CUSIC_STN_PUNCH 2'h2

// ****************************************
// Level 1 status bit positions
// ****************************************
`define CUSIC_ST_READY 0
`define CUSIC_ST_BUSY 1
`define CUSIC_ST_INT 2
`define CUSIC_ST_DATA 3
`define CUSIC_ST_EOP 4
`define CUSIC_ST_ALARM 5
// Level 2 status bit positions
`define CUSIC_L2_ALARM 0

// ****************************************
// Function word bit positions
// ****************************************
`define CUSIC_FN_CLR_CTRL 0
`define CUSIC_FN_CLR_INT 1
`define CUSIC_FN_SEL_DATA 2
`define CUSIC_FN_SEL_EOP 3
`define CUSIC_FN_SEL_ALARM 4
`define CUSIC_FN_FEED 5
`define CUSIC_FN_ALL 16'h003F

// ****************************************
// APB register map and reset values
// ****************************************
`define CUSIC_OFS_EVENTS 8'h00
`define CUSIC_OFS_MASK 8'h04
`define CUSIC_OFS_COLS 8'h08
`define CUSIC_OFS_LEVEL1 8'h0C
`define CUSIC_OFS_LEVEL2 8'h10
`define CUSIC_EV_DATA 0
`define CUSIC_EV_EOP 1
`define CUSIC_EV_ALARM 2
`define CUSIC_MASK_RST 3'h0

`endif

//--- logic/cusic_col_pacer.v
// Column pacer of the punch: paces column requests and counts one card.
// Assumes start and colTake are single-cycle pulses on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "cusic_consts.vh"

module cusic_col_pacer #(
    parameter [19:0] COL_CYCLES = `CUSIC_COL_CYCLES
) (
    // Clock and reset
    input wire clock,
    input wire rst,
    // Control
    input wire clear,
    input wire start,
    input wire colTake,
    // State
    output reg colReady,
    output reg cardDone,
    output reg [6:0] colCount
);

    reg [19:0] timer_q;
    reg running_q;

    // ****************************************
    // Column timing
    // ****************************************
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            timer_q <= 20'h00000;
            running_q <= 1'b0;
            colReady <= 1'b0;
            cardDone <= 1'b0;
            colCount <= 7'h00;
        end else if (clear) begin
            running_q <= 1'b0;
            colReady <= 1'b0;
            cardDone <= 1'b0;
            colCount <= 7'h00;
        end else begin
            cardDone <= 1'b0;
            if (start) begin
                running_q <= 1'b1;
                timer_q <= COL_CYCLES - 20'h00001;
                colCount <= 7'h00;
                colReady <= 1'b0;
            end else if (running_q) begin
                if (colTake) begin
                    colCount <= colCount + 7'h01;
                    colReady <= 1'b0;
                    timer_q <= COL_CYCLES - 20'h00001;
                end else if (!colReady) begin
                    if (timer_q != 20'h00000) begin
                        timer_q <= timer_q - 20'h00001;
                    end else if (colCount == `CUSIC_COLS_PER_CARD) begin
                        // Card ends after exactly the last column
                        running_q <= 1'b0;
                        cardDone <= 1'b1;
                    end else begin
                        colReady <= 1'b1;
                    end
                end
            end
        end
    end

endmodule
`default_nettype wire

//--- logic/cusic_top.v
// Station controller of a card reader/punch on a parallel I/O channel,
// with an APB slave for interrupt events, mask and status mirrors.
// Assumes the channel requester runs on the same clock and holds chReq
// with its qualifiers steady until it sees an answer or gives up.
`timescale 1ns/1ps
`default_nettype none
`include "cusic_consts.vh"

// How it works
// - Level 1 status on station 0 replies and shows Ready.
// - Level 1 status on station 3 replies and shows Ready.
// - All-functions word on station 0 gets no answer; status stays Ready.
// - All-functions word on punch station gets no answer, changes nothing.
// - Idle punch Level 1 status replies with Data and Ready.
// - Punch Level 2 status replies, all zero without faults.
// - Clear controller on punch replies; idle status then Data and Ready.
// - Clear interrupts on punch replies; idle status stays Data and Ready.
// - Data, end-of-operation and alarm interrupts are separate and maskable.
// - Data interrupt select with data present raises data interrupt only.
// - End-of-operation select on idle punch raises no interrupt.
// - Undefined function bits on punch reply and change nothing.
// - All functions but feed reply and raise only the data interrupt.
// - A card is exactly 80 counted columns.
// - Reader station idle shows Ready only; data interrupt request ignored.
module cusic_top #(
    parameter [19:0] COL_CYCLES = `CUSIC_COL_CYCLES
) (
    // Clock and reset
    input wire clock,
    input wire rst,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Channel
    input wire chReq,
    input wire chWrite,
    input wire chDirector,
    input wire chLevel2,
    input wire [1:0] chStation,
    input wire [15:0] chDataIn,
    output reg chReply,
    output reg chReject,
    output reg [15:0] chDataOut,
    // Punch mechanism
    input wire punchAlarmPin,
    output reg [11:0] colData,
    output reg colStrobe,
    // Interrupt lines
    output reg irqDataLine,
    output reg irqEopLine,
    output reg irqAlarmLine,
    output reg irq
);

    localparam [1:0] CH_IDLE = 2'b01;
    localparam [1:0] CH_HOLD = 2'b10;

    reg [1:0] chState_q;
    reg alarmMeta_q, alarmSync_q;
    reg busy_q, eop_q, alarm_q;
    reg selData_q, selEop_q, selAlarm_q, eopPend_q;
    reg [2:0] events_q, mask_q;
    reg reply_d, reject_d, doFunc, doCol;
    reg [15:0] word_d;
    reg [31:0] rdMux;
    reg rdBad;
    wire pacReady, pacDone;
    wire [6:0] pacCols;

    // ****************************************
    // Status composition
    // ****************************************
    function [15:0] level1Word;
        input ready, busy, intr, data, eop, alarm;
        begin
            level1Word = 16'h0000;
            level1Word[`CUSIC_ST_READY] = ready;
            level1Word[`CUSIC_ST_BUSY] = busy;
            level1Word[`CUSIC_ST_INT] = intr;
            level1Word[`CUSIC_ST_DATA] = data;
            level1Word[`CUSIC_ST_EOP] = eop;
            level1Word[`CUSIC_ST_ALARM] = alarm;
        end
    endfunction

    // Idle punch always wants a column; busy punch only when paced
    wire dataSt = ~busy_q | pacReady;
    wire dataPend = selData_q & dataSt;
    wire alarmPend = selAlarm_q & alarm_q;
    wire anyPend = dataPend | eopPend_q | alarmPend;
    wire [15:0] punchL1 = level1Word(1'b1, busy_q, anyPend, dataSt, eop_q, alarm_q);
    wire [15:0] idleL1 = level1Word(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    wire [15:0] punchL2 = {15'h0000, alarm_q};
    wire stPunch = (chStation == `CUSIC_STN_PUNCH);
    wire funcAll = ((chDataIn & `CUSIC_FN_ALL) == `CUSIC_FN_ALL);
    wire take = chState_q[0] & chReq;

    // ****************************************
    // Channel request decode
    // ****************************************
    always @* begin
        reply_d = 1'b0;
        reject_d = 1'b0;
        doFunc = 1'b0;
        doCol = 1'b0;
        word_d = 16'h0000;
        if (chDirector && !chWrite) begin
            reply_d = 1'b1;
            if (stPunch) begin
                word_d = chLevel2 ? punchL2 : punchL1;
            end else begin
                word_d = idleL1;
            end
        end else if (chDirector && chWrite) begin
            // No answer at all: the requester's timeout ends it
            if (chStation != `CUSIC_STN_ZERO && !funcAll) begin
                reply_d = 1'b1;
                doFunc = 1'b1;
            end
        end else if (chWrite && stPunch && busy_q && pacReady) begin
            reply_d = 1'b1;
            doCol = 1'b1;
        end else begin
            reject_d = 1'b1;
        end
    end

    always @(posedge clock or posedge rst) begin
        if (rst) begin
            chState_q <= CH_IDLE;
            chReply <= 1'b0;
            chReject <= 1'b0;
            chDataOut <= 16'h0000;
        end else begin
            chReply <= 1'b0;
            chReject <= 1'b0;
            case (chState_q)
                CH_IDLE: begin
                    if (chReq) begin
                        chReply <= reply_d;
                        chReject <= reject_d;
                        chDataOut <= word_d;
                        chState_q <= CH_HOLD;
                    end
                end
                CH_HOLD: begin
                    if (!chReq) begin
                        chState_q <= CH_IDLE;
                    end
                end
                default: begin
                    chState_q <= CH_IDLE;
                end
            endcase
        end
    end

    // ****************************************
    // Function execution and punch state
    // ****************************************
    wire fn = take & doFunc;
    wire clrCtrl = fn & chDataIn[`CUSIC_FN_CLR_CTRL];
    wire clrInt = fn & chDataIn[`CUSIC_FN_CLR_INT];
    wire selD = fn & stPunch & chDataIn[`CUSIC_FN_SEL_DATA];
    wire selE = fn & stPunch & chDataIn[`CUSIC_FN_SEL_EOP];
    wire selA = fn & stPunch & chDataIn[`CUSIC_FN_SEL_ALARM];
    wire feed = fn & stPunch & chDataIn[`CUSIC_FN_FEED] & ~busy_q & ~clrCtrl;
    wire colTake = take & doCol;

    // Alarm arrives from the mechanism, so it is synchronised first
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            alarmMeta_q <= 1'b0;
            alarmSync_q <= 1'b0;
        end else begin
            alarmMeta_q <= punchAlarmPin;
            alarmSync_q <= alarmMeta_q;
        end
    end

    always @(posedge clock or posedge rst) begin
        if (rst) begin
            busy_q <= 1'b0;
            eop_q <= 1'b0;
            alarm_q <= 1'b0;
            selData_q <= 1'b0;
            selEop_q <= 1'b0;
            selAlarm_q <= 1'b0;
            eopPend_q <= 1'b0;
            colData <= 12'h000;
            colStrobe <= 1'b0;
        end else begin
            colStrobe <= colTake;
            if (colTake) begin
                colData <= chDataIn[11:0];
            end
            // Clears act first so a combined word can reselect afterwards
            if (clrCtrl || clrInt) begin
                selData_q <= 1'b0;
                selEop_q <= 1'b0;
                selAlarm_q <= 1'b0;
                eopPend_q <= 1'b0;
            end
            if (clrCtrl) begin
                busy_q <= 1'b0;
                alarm_q <= 1'b0;
            end
            if (selD) begin
                selData_q <= 1'b1;
            end
            if (selE) begin
                selEop_q <= 1'b1;
            end
            if (selA) begin
                selAlarm_q <= 1'b1;
            end
            if (feed) begin
                busy_q <= 1'b1;
                eop_q <= 1'b0;
            end
            // A controller clear in the same cycle wins over card done for busy and EOP state; the alarm wins over a clear
            if (pacDone && !clrCtrl) begin
                busy_q <= 1'b0;
                eop_q <= 1'b1;
                eopPend_q <= selEop_q | selE;
            end
            if (alarmSync_q) begin
                alarm_q <= 1'b1;
            end
        end
    end

    cusic_col_pacer #(
        .COL_CYCLES(COL_CYCLES)
    ) pacer (
        .clock(clock),
        .rst(rst),
        .clear(clrCtrl),
        .start(feed),
        .colTake(colTake),
        .colReady(pacReady),
        .cardDone(pacDone),
        .colCount(pacCols)
    );

    // ****************************************
    // Interrupt lines and event register
    // ****************************************
    wire apbAccess = psel & penable & pready;
    wire apbWr = apbAccess & pwrite;
    wire [2:0] evSet = {alarmPend & ~irqAlarmLine, pacDone & selEop_q, dataPend & ~irqDataLine};
    wire [2:0] evClr = (apbWr && paddr == `CUSIC_OFS_EVENTS) ? pwdata[2:0] : 3'h0;
    wire [2:0] evNext = (events_q & ~evClr) | evSet;

    always @(posedge clock or posedge rst) begin
        if (rst) begin
            irqDataLine <= 1'b0;
            irqEopLine <= 1'b0;
            irqAlarmLine <= 1'b0;
            events_q <= 3'h0;
            mask_q <= `CUSIC_MASK_RST;
            irq <= 1'b0;
        end else begin
            irqDataLine <= dataPend;
            irqEopLine <= eopPend_q;
            irqAlarmLine <= alarmPend;
            events_q <= evNext;
            if (apbWr && paddr == `CUSIC_OFS_MASK) begin
                mask_q <= pwdata[2:0];
            end
            irq <= |(evNext & mask_q);
        end
    end

    // ****************************************
    // APB slave
    // ****************************************
    always @* begin
        rdMux = 32'h00000000;
        rdBad = 1'b0;
        if (paddr == `CUSIC_OFS_EVENTS) begin
            rdMux = {29'h00000000, events_q};
        end else if (paddr == `CUSIC_OFS_MASK) begin
            rdMux = {29'h00000000, mask_q};
        end else if (paddr == `CUSIC_OFS_COLS) begin
            rdMux = {25'h0000000, pacCols};
        end else if (paddr == `CUSIC_OFS_LEVEL1) begin
            rdMux = {16'h0000, punchL1};
        end else if (paddr == `CUSIC_OFS_LEVEL2) begin
            rdMux = {16'h0000, punchL2};
        end else begin
            rdBad = 1'b1;
        end
    end

    // One wait state: data is registered on the same edge that raises pready
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else if (psel && penable && !pready) begin
            pready <= 1'b1;
            pslverr <= rdBad;
            prdata <= pwrite ? 32'h00000000 : rdMux;
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

endmodule
`default_nettype wire

//--- test/cusic_top_props.sv
// Checker of the station controller: channel answers, APB handshake, interrupt lines.
// Assumes one clock domain and an asynchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module cusic_top_props (
    // Clock and reset
    input wire clock,
    input wire rst,
    // APB
    input wire psel,
    input wire penable,
    input wire pready,
    input wire pslverr,
    // Channel
    input wire chReq,
    input wire chWrite,
    input wire chDirector,
    input wire [1:0] chStation,
    input wire [15:0] chDataIn,
    input wire chReply,
    input wire chReject,
    input wire [15:0] chDataOut,
    // Punch and interrupts
    input wire colStrobe,
    input wire irqDataLine,
    input wire irqEopLine,
    input wire irqAlarmLine
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    logic reqPrev_q;
    // A request counts once: the controller ignores a held request after taking it
    always_ff @(posedge clock or posedge rst) begin
        if (rst) reqPrev_q <= 1'b0;
        else reqPrev_q <= chReq;
    end
    wire newReq = chReq && !reqPrev_q;
    wire fnReq = newReq && chWrite && chDirector;
    wire stReq = newReq && !chWrite && chDirector;
    wire anyLine = irqDataLine || irqEopLine || irqAlarmLine;

    AST_STATUS_REPLY:
        assert property (stReq |=> chReply && !chReject) else $error("status input not replied");
    AST_SIDE_READY:
        assert property (stReq && chStation != 2'h2 |=> chDataOut == 16'h0001)
        else $error("side station status not ready only");
    AST_ALLFN_SILENT:
        assert property (fnReq && chDataIn[5:0] == 6'h3F |=> (!chReply && !chReject)[*3])
        else $error("all-functions word was answered");
    AST_STN0_SILENT:
        assert property (fnReq && chStation == 2'h0 |=> (!chReply && !chReject)[*3])
        else $error("function on station zero was answered");
    AST_FN_REPLY:
        assert property (fnReq && chStation != 2'h0 && chDataIn[5:0] != 6'h3F |=> chReply)
        else $error("function not replied");
    AST_DIN_REJECT:
        assert property (newReq && !chWrite && !chDirector |=> chReject && !chReply)
        else $error("data input not rejected");
    AST_CLEAR_LINES:
        assert property (fnReq && chStation != 2'h0 && chDataIn[1:0] != 2'h0
            && chDataIn[5:2] == 4'h0 |-> ##[1:2] !anyLine) else $error("clear left a line up");
    AST_PEND_HOLD:
        assert property (irqDataLine && !chReq && !$past(chReq) |=> irqDataLine)
        else $error("data interrupt dropped without a clear");
    AST_DATA_ONLY:
        assert property (fnReq && chStation == 2'h2 && chDataIn[5:0] == 6'h04 && !anyLine
            |-> ##[1:2] (irqDataLine && !irqEopLine && !irqAlarmLine))
        else $error("data interrupt select raised wrong lines");
    AST_STROBE:
        assert property (newReq && chWrite && !chDirector ##1 chReply |-> ##[0:1] colStrobe)
        else $error("accepted column not strobed");
    AST_APB_WAIT:
        assert property (psel && penable && !pready |=> pready) else $error("APB ready late");
    AST_ERR_WITH_READY:
        assert property (pslverr |-> pready) else $error("APB error without ready");
    cover property (fnReq && chDataIn[5:0] == 6'h3F);
    cover property (stReq ##1 chReply);
    cover property (colStrobe);
    cover property ($rose(irqEopLine));
endmodule
bind cusic_top cusic_top_props u_props (.clock(clock), .rst(rst), .psel(psel),
    .penable(penable), .pready(pready), .pslverr(pslverr), .chReq(chReq), .chWrite(chWrite),
    .chDirector(chDirector), .chStation(chStation), .chDataIn(chDataIn), .chReply(chReply),
    .chReject(chReject), .chDataOut(chDataOut), .colStrobe(colStrobe),
    .irqDataLine(irqDataLine), .irqEopLine(irqEopLine), .irqAlarmLine(irqAlarmLine));
`default_nettype wire

//--- test/cusic_host_model.sv
// Host channel model: one request at a time, gives up when nothing answers.
// Assumes the controller runs on the same clock.
`timescale 1ns/1ps
`default_nettype none
module cusic_host_model #(
    parameter int TIMEOUT = 12
) (
    // Clock
    input wire logic clock,
    // Answers
    input wire logic chReply,
    input wire logic chReject,
    input wire logic [15:0] chDataOut,
    // Request
    output logic chReq,
    output logic chWrite,
    output logic chDirector,
    output logic chLevel2,
    output logic [1:0] chStation,
    output logic [15:0] chDataIn
);
    // Equipment code decode sits upstream of chReq; only this code is issued
    localparam logic [6:0] EQUIP_CODE = 7'h01;
    initial begin
        chReq = 1'b0;
        chWrite = 1'b0;
        chDirector = 1'b0;
        chLevel2 = 1'b0;
        chStation = 2'h0;
        chDataIn = 16'h0000;
    end
    // ans: 01 reply, 10 reject, 00 internal reject after the timeout
    task automatic xfer(input logic wr, input logic dir, input logic lvl2,
        input logic [1:0] stn, input logic [15:0] dat, input int gap,
        output logic [1:0] ans, output logic [15:0] word);
        int n;
        repeat (gap) @(posedge clock);
        @(posedge clock);
        chReq <= 1'b1;
        chWrite <= wr;
        chDirector <= dir;
        chLevel2 <= lvl2;
        chStation <= stn;
        chDataIn <= dat;
        ans = 2'b00;
        n = 0;
        while (ans == 2'b00 && n < TIMEOUT) begin
            @(posedge clock);
            n++;
            if (chReply) ans = 2'b01;
            else if (chReject) ans = 2'b10;
        end
        word = chDataOut;
        chReq <= 1'b0;
        // Released data lines show the inverse of the last value, never the last value
        chDataIn <= ~dat;
    endtask
endmodule
`default_nettype wire

//--- test/cusic_top_tb.sv
// Testbench of the station controller: host model on the channel, APB tasks on registers.
// Assumes cusic_top, the host model and the checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none
`include "cusic_consts.vh"
module cusic_top_tb;
    localparam logic [1:0] REPLY = 2'b01;
    localparam logic [1:0] REJECT = 2'b10;
    localparam logic [1:0] SILENT = 2'b00;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, punchAlarmPin = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, rdat;
    logic rerr;
    logic [1:0] ans;
    logic [15:0] word;
    wire logic [31:0] prdata;
    wire logic pready, pslverr, chReq, chWrite, chDirector, chLevel2, chReply, chReject;
    wire logic colStrobe, irqDataLine, irqEopLine, irqAlarmLine, irq;
    wire logic [1:0] chStation;
    wire logic [15:0] chDataIn, chDataOut;
    wire logic [11:0] colData;
    int errorCnt = 0, comparisons = 0, strobeCnt = 0;

    // Short column time keeps a whole card within a few thousand cycles
    cusic_top #(.COL_CYCLES(20'd8)) DUT (.clock(clock), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .chReq(chReq), .chWrite(chWrite),
        .chDirector(chDirector), .chLevel2(chLevel2), .chStation(chStation),
        .chDataIn(chDataIn), .chReply(chReply), .chReject(chReject), .chDataOut(chDataOut),
        .punchAlarmPin(punchAlarmPin), .colData(colData), .colStrobe(colStrobe),
        .irqDataLine(irqDataLine), .irqEopLine(irqEopLine), .irqAlarmLine(irqAlarmLine),
        .irq(irq));
    cusic_host_model host (.clock(clock), .chReply(chReply), .chReject(chReject),
        .chDataOut(chDataOut), .chReq(chReq), .chWrite(chWrite), .chDirector(chDirector),
        .chLevel2(chLevel2), .chStation(chStation), .chDataIn(chDataIn));

    initial forever #5 clock = ~clock;
    always @(posedge clock) if (colStrobe === 1'b1) strobeCnt++;

    // ****************************************
    // Bus and compare tasks
    // ****************************************
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            errorCnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] adr, input logic [31:0] wd);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= adr;
        pwdata <= wd;
        @(posedge clock);
        penable <= 1'b1;
        // Waits for the answer; only the watchdog ends a hang
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] adr, input logic [31:0] exp, input logic experr);
        apb(1'b0, adr, 32'h0);
        chk("apb read data", exp, rdat);
        chk("apb error", {31'h0, experr}, {31'h0, rerr});
    endtask
    task automatic st(input logic [1:0] stn, input logic lvl2, input logic [15:0] exp);
        host.xfer(1'b0, 1'b1, lvl2, stn, 16'h0000, 0, ans, word);
        chk("status answer", {30'h0, REPLY}, {30'h0, ans});
        chk("status word", {16'h0, exp}, {16'h0, word});
    endtask
    task automatic fn(input logic [1:0] stn, input logic [15:0] dat, input logic [1:0] exp);
        host.xfer(1'b1, 1'b1, 1'b0, stn, dat, 0, ans, word);
        chk("function answer", {30'h0, exp}, {30'h0, ans});
    endtask
    task automatic lines(input logic [2:0] exp);
        repeat (2) @(posedge clock);
        #1;
        chk("interrupt lines", {29'h0, exp}, {29'h0, irqDataLine, irqEopLine, irqAlarmLine});
    endtask
    task automatic irqIs(input logic exp);
        repeat (2) @(posedge clock);
        #1;
        chk("irq", {31'h0, exp}, {31'h0, irq});
    endtask
    task automatic wrap_up;
        if (errorCnt == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_regs;
        rdc(`CUSIC_OFS_MASK, 32'h0, 1'b0);
        rdc(`CUSIC_OFS_EVENTS, 32'h0, 1'b0);
        apb(1'b1, 8'h14, 32'h7);
        rdc(8'h14, 32'h0, 1'b1);
        rdc(`CUSIC_OFS_MASK, 32'h0, 1'b0);
        rdc(`CUSIC_OFS_LEVEL1, 32'h9, 1'b0);
        rdc(`CUSIC_OFS_LEVEL2, 32'h0, 1'b0);
    endtask
    task automatic t_static;
        st(2'h0, 1'b0, 16'h0001);
        st(2'h3, 1'b0, 16'h0001);
        st(2'h1, 1'b0, 16'h0001);
        st(2'h2, 1'b0, 16'h0009);
        st(2'h2, 1'b1, 16'h0000);
    endtask
    task automatic t_silent;
        fn(2'h0, 16'hFFFF, SILENT);
        st(2'h0, 1'b0, 16'h0001);
        fn(2'h2, 16'h003F, SILENT);
        st(2'h2, 1'b0, 16'h0009);
        st(2'h2, 1'b1, 16'h0000);
    endtask
    task automatic t_clears;
        fn(2'h2, 16'h0001, REPLY);
        st(2'h2, 1'b0, 16'h0009);
        fn(2'h2, 16'h0002, REPLY);
        st(2'h2, 1'b0, 16'h0009);
    endtask
    task automatic t_irq;
        apb(1'b1, `CUSIC_OFS_MASK, 32'h7);
        fn(2'h2, 16'h0004, REPLY);
        lines(3'b100);
        st(2'h2, 1'b0, 16'h000D);
        irqIs(1'b1);
        rdc(`CUSIC_OFS_EVENTS, 32'h1, 1'b0);
        apb(1'b1, `CUSIC_OFS_MASK, 32'h6);
        irqIs(1'b0);
        apb(1'b1, `CUSIC_OFS_MASK, 32'h7);
        apb(1'b1, `CUSIC_OFS_EVENTS, 32'h1);
        rdc(`CUSIC_OFS_EVENTS, 32'h0, 1'b0);
        irqIs(1'b0);
        fn(2'h2, 16'h0002, REPLY);
        lines(3'b000);
        st(2'h2, 1'b0, 16'h0009);
    endtask
    task automatic t_quiet;
        fn(2'h2, 16'h0008, REPLY);
        lines(3'b000);
        st(2'h2, 1'b0, 16'h0009);
        fn(2'h2, 16'hFFC0, REPLY);
        st(2'h2, 1'b0, 16'h0009);
        fn(2'h2, 16'h001F, REPLY);
        lines(3'b100);
        st(2'h2, 1'b0, 16'h000D);
        fn(2'h2, 16'h0001, REPLY);
        lines(3'b000);
    endtask
    task automatic t_reader;
        fn(2'h1, 16'h0004, REPLY);
        lines(3'b000);
        st(2'h1, 1'b0, 16'h0001);
        host.xfer(1'b0, 1'b0, 1'b0, 2'h1, 16'h0000, 2, ans, word);
        chk("data input answer", {30'h0, REJECT}, {30'h0, ans});
    endtask
    task automatic t_alarm;
        fn(2'h2, 16'h0010, REPLY);
        punchAlarmPin <= 1'b1;
        // Two synchroniser stages, the alarm flag and the line register
        repeat (4) @(posedge clock);
        lines(3'b001);
        @(posedge clock);
        punchAlarmPin <= 1'b0;
        st(2'h2, 1'b1, 16'h0001);
        st(2'h2, 1'b0, 16'h002D);
        fn(2'h2, 16'h0001, REPLY);
        lines(3'b000);
    endtask
    task automatic t_card;
        int cols;
        int tries;
        strobeCnt = 0;
        cols = 0;
        tries = 0;
        fn(2'h2, 16'h0028, REPLY);
        // Early attempts are refused until the column is wanted, so retry
        while (cols < 80 && tries < 3000) begin
            host.xfer(1'b1, 1'b0, 1'b0, 2'h2, {4'h0, cols[11:0] ^ 12'h555}, 0, ans, word);
            tries++;
            if (ans == REPLY) cols++;
        end
        chk("columns accepted", 32'd80, cols);
        host.xfer(1'b1, 1'b0, 1'b0, 2'h2, 16'h0123, 0, ans, word);
        chk("extra column answer", {30'h0, REJECT}, {30'h0, ans});
        tries = 0;
        do begin
            host.xfer(1'b0, 1'b1, 1'b0, 2'h2, 16'h0000, 4, ans, word);
            tries++;
        end while (word[1] !== 1'b0 && tries < 50);
        chk("end of operation bit", 32'h1, {31'h0, word[4]});
        chk("strobes", 32'd80, strobeCnt);
        chk("last column", {20'h0, 12'h555 ^ 12'd79}, {20'h0, colData});
        lines(3'b010);
        rdc(`CUSIC_OFS_COLS, 32'd80, 1'b0);
        fn(2'h2, 16'h0001, REPLY);
    endtask

    initial begin
        repeat (20) @(posedge clock);
        rst <= 1'b0;
        t_regs;
        t_static;
        t_silent;
        t_clears;
        t_irq;
        t_quiet;
        t_reader;
        t_alarm;
        t_card;
        wrap_up;
    end
    initial begin
        #200000;
        errorCnt++;
        wrap_up;
    end
endmodule
`default_nettype wire
